// >>> inc/ofr_defines.svh
// Offsets, field positions and reset values of the offcore response filter
`ifndef OFR_DEFINES_SVH
`define OFR_DEFINES_SVH
// Wishbone word offsets (byte addresses)
`define OFR_ADR_PRIM_LO   8'h00
`define OFR_ADR_PRIM_HI   8'h04
`define OFR_ADR_SEC_LO    8'h08
`define OFR_ADR_SEC_HI    8'h0C
`define OFR_ADR_CNT0      8'h10
`define OFR_ADR_CNT1      8'h14
`define OFR_ADR_STATUS    8'h18
// Filter field positions
`define OFR_REQ_LO_MSB    15
`define OFR_REQ_HI_LSB    44
`define OFR_REQ_HI_MSB    49
`define OFR_ANY_BIT       16
`define OFR_SUP_LSB       17
`define OFR_SUP_MSB       30
`define OFR_SNP_LSB       31
`define OFR_SNP_MSB       37
`define OFR_INFL_BIT      63
`define OFR_DEMAND_RD_BIT 0
// Non-reserved request bits within 15:0 (9:7 and 14:13 are reserved)
`define OFR_REQ_LO_MASK   16'h9C7F
// Reset values
`define OFR_FILT_RST      64'h0000000000000000
`define OFR_CNT_RST       32'h00000000
`define OFR_OCC_RST       8'h00
// Status register field position
`define OFR_ST_FAULT_BIT  0
`define OFR_ST_INFL_BIT   1
`define OFR_ST_OCC_LSB    8
`endif

// >>> inc/ofr_pkg.sv
// Types shared by the offcore response filter
package ofr_pkg;
  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ofr_wb_req_t;
  // Wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ofr_wb_rsp_t;
  // Transaction leaving the core, one-cycle valid
  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic        prefetch;
    logic [15:0] req_lo;
    logic [5:0]  req_hi;
    logic [13:0] supplier;
    logic [6:0]  snoop;
  } ofr_txn_t;
  // Completion of an outstanding transaction, one-cycle valid
  typedef struct packed {
    logic        valid;
    logic        prefetch;
    logic [15:0] req_lo;
    logic [5:0]  req_hi;
  } ofr_cpl_t;
endpackage

// >>> design/ofr_filter.sv
// Offcore response event filter with two filter registers and counters
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "ofr_defines.svh"
module ofr_filter
  import ofr_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  input  wire ofr_wb_req_t WB_REQ_IN,
  output ofr_wb_rsp_t      WB_RSP_OUT,
  input  wire ofr_txn_t    TXN_IN,
  input  wire ofr_cpl_t    CPL_IN,
  output logic             FAULT_OUT,
  output logic [31:0]      COUNT0_OUT,
  output logic [31:0]      COUNT1_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [63:0] prim_q;     // Primary filter
  logic [63:0] sec_q;      // Secondary filter, bit 63 never set
  logic [31:0] cnt0_q;     // Counter behind the primary filter
  logic [31:0] cnt1_q;     // Counter behind the secondary filter
  logic [7:0]  occ_q;      // Outstanding matching requests
  logic        fault_q;    // Sticky protection fault
  logic        fault_p_q;  // One-cycle fault pulse
  logic        ack_q;      // Bus acknowledge
  logic [31:0] rdat_q;     // Read data
  logic        bus_req;    // Request waiting for answer
  logic        wr_fire;    // Write takes effect this edge
  logic        bad_wr;     // Write of 1 to secondary bit 63
  logic        infl;       // Primary in in-flight mode
  logic        hit0;       // Transaction counts on primary
  logic        hit1;       // Transaction counts on secondary
  logic        iss0;       // Issue matches primary requests
  logic        cpl0;       // Completion matches primary requests
  logic [31:0] rd_mux;     // Selected read word

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Request match over the non-reserved request bits
  function automatic logic req_match(input logic [63:0] f, input logic pf,
                                     input logic [15:0] lo, input logic [5:0] hi);
    logic [15:0] m;
    m = f[`OFR_REQ_LO_MSB:0] & `OFR_REQ_LO_MASK & lo;
    // A prefetch is never a true demand load
    if (pf) begin
      m[`OFR_DEMAND_RD_BIT] = 1'b0;
    end
    return (|m) | (|(f[`OFR_REQ_HI_MSB:`OFR_REQ_HI_LSB] & hi));
  endfunction

  // Request and response match of one transaction
  function automatic logic txn_match(input logic [63:0] f, input ofr_txn_t t);
    logic any;
    logic sup;
    logic snp;
    any = f[`OFR_ANY_BIT];
    // Cache-state hits, memory hit and other suppliers
    sup = |(f[`OFR_SUP_MSB:`OFR_SUP_LSB] & t.supplier);
    // Snoop outcomes, modified forward and non-memory target
    snp = |(f[`OFR_SNP_MSB:`OFR_SNP_LSB] & t.snoop);
    // Catch-all wins over every other response bit
    if (any) begin
      sup = 1'b1;
      snp = 1'b1;
    end
    // Writes ignore snoop selections
    if (t.is_write) begin
      snp = 1'b1;
    end
    return t.valid & sup & snp
           & req_match(f, t.prefetch, t.req_lo, t.req_hi);
  endfunction

  // Byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Matching
  assign infl    = prim_q[`OFR_INFL_BIT];
  // In-flight mode counts occupancy, not occurrences
  assign hit0    = txn_match(prim_q, TXN_IN) & ~infl;
  assign hit1    = txn_match(sec_q, TXN_IN);
  assign iss0    = TXN_IN.valid & req_match(prim_q, TXN_IN.prefetch,
                                            TXN_IN.req_lo, TXN_IN.req_hi);
  assign cpl0    = CPL_IN.valid & req_match(prim_q, CPL_IN.prefetch,
                                            CPL_IN.req_lo, CPL_IN.req_hi);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack for exactly one cycle
  assign bus_req = WB_REQ_IN.cyc & WB_REQ_IN.stb;
  // Writes act only at the edge where the master sees ack
  assign wr_fire = bus_req & WB_REQ_IN.we & ack_q;
  // Setting bit 63 of the secondary filter is refused with a fault
  assign bad_wr  = wr_fire & (WB_REQ_IN.adr == `OFR_ADR_SEC_HI)
                   & WB_REQ_IN.sel[3] & WB_REQ_IN.dat[31];

  // Acknowledge, dropped in the cycle after it is given
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (WB_REQ_IN.adr)
      `OFR_ADR_PRIM_LO: rd_mux = prim_q[31:0];
      `OFR_ADR_PRIM_HI: rd_mux = prim_q[63:32];
      `OFR_ADR_SEC_LO:  rd_mux = sec_q[31:0];
      `OFR_ADR_SEC_HI:  rd_mux = sec_q[63:32];
      `OFR_ADR_CNT0:    rd_mux = cnt0_q;
      `OFR_ADR_CNT1:    rd_mux = cnt1_q;
      `OFR_ADR_STATUS: begin
        rd_mux[`OFR_ST_FAULT_BIT] = fault_q;
        rd_mux[`OFR_ST_INFL_BIT]  = infl;
        rd_mux[`OFR_ST_OCC_LSB +: 8] = occ_q;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data captured as ack rises, held otherwise
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdat_q <= 32'h00000000;
    end else if (bus_req & ~ack_q) begin
      rdat_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter registers
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      prim_q <= `OFR_FILT_RST;
      sec_q  <= `OFR_FILT_RST;
    end else if (wr_fire) begin
      unique case (WB_REQ_IN.adr)
        `OFR_ADR_PRIM_LO: prim_q[31:0]  <= merge(prim_q[31:0], WB_REQ_IN.dat,
                                                 WB_REQ_IN.sel);
        `OFR_ADR_PRIM_HI: prim_q[63:32] <= merge(prim_q[63:32], WB_REQ_IN.dat,
                                                 WB_REQ_IN.sel);
        `OFR_ADR_SEC_LO:  sec_q[31:0]   <= merge(sec_q[31:0], WB_REQ_IN.dat,
                                                 WB_REQ_IN.sel);
        `OFR_ADR_SEC_HI: begin
          // A faulting write leaves the whole word untouched
          if (!bad_wr) begin
            sec_q[63:32] <= merge(sec_q[63:32], WB_REQ_IN.dat,
                                  WB_REQ_IN.sel);
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flag: set wins over write-one-to-clear
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fault_q   <= 1'b0;
      fault_p_q <= 1'b0;
    end else begin
      fault_p_q <= bad_wr;
      if (bad_wr) begin
        fault_q <= 1'b1;
      end else if (wr_fire && WB_REQ_IN.adr == `OFR_ADR_STATUS
                   && WB_REQ_IN.sel[0] && WB_REQ_IN.dat[`OFR_ST_FAULT_BIT]) begin
        fault_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Occupancy of matching requests; saturates rather than wraps
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      occ_q <= `OFR_OCC_RST;
    end else if (iss0 && !cpl0 && occ_q != 8'hFF) begin
      occ_q <= occ_q + 8'h01;
    end else if (cpl0 && !iss0 && occ_q != 8'h00) begin
      occ_q <= occ_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters; a software preset wins over counting in that cycle
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cnt0_q <= `OFR_CNT_RST;
    end else if (wr_fire && WB_REQ_IN.adr == `OFR_ADR_CNT0) begin
      cnt0_q <= merge(cnt0_q, WB_REQ_IN.dat, WB_REQ_IN.sel);
    end else if (infl) begin
      cnt0_q <= cnt0_q + {24'h000000, occ_q};
    end else if (hit0) begin
      cnt0_q <= cnt0_q + 32'h00000001;
    end
  end

  // Secondary counter counts occurrences, never occupancy
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cnt1_q <= `OFR_CNT_RST;
    end else if (wr_fire && WB_REQ_IN.adr == `OFR_ADR_CNT1) begin
      cnt1_q <= merge(cnt1_q, WB_REQ_IN.dat, WB_REQ_IN.sel);
    end else if (hit1) begin
      cnt1_q <= cnt1_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign WB_RSP_OUT.ack = ack_q;
  assign WB_RSP_OUT.dat = rdat_q;
  assign FAULT_OUT      = fault_p_q;
  assign COUNT0_OUT     = cnt0_q;
  assign COUNT1_OUT     = cnt1_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence s_sec_hi_set;
    wr_fire && WB_REQ_IN.adr == `OFR_ADR_SEC_HI
      && WB_REQ_IN.sel[3] && WB_REQ_IN.dat[31];
  endsequence
  sequence s_no_sw0;
    !(wr_fire && WB_REQ_IN.adr == `OFR_ADR_CNT0);
  endsequence
  sequence s_no_sw1;
    !(wr_fire && WB_REQ_IN.adr == `OFR_ADR_CNT1);
  endsequence

  AST_SEC63_ZERO: assert property (!sec_q[63])
    else $error("secondary bit 63 set");
  AST_FAULT: assert property (s_sec_hi_set |=> fault_q && FAULT_OUT
                              && $stable(sec_q))
    else $error("fault not raised or write not refused");
  AST_CNT0_INC: assert property (TXN_IN.valid && !infl && hit0
                                 ##0 s_no_sw0 |=> cnt0_q == $past(cnt0_q) + 32'h1)
    else $error("primary counter missed a match");
  AST_INFL_ACC: assert property (infl ##0 s_no_sw0
                                 |=> cnt0_q == $past(cnt0_q) + {24'h0, $past(occ_q)})
    else $error("in-flight accumulation wrong");
  AST_ANY_WINS: assert property (TXN_IN.valid && sec_q[`OFR_ANY_BIT]
      && req_match(sec_q, TXN_IN.prefetch, TXN_IN.req_lo, TXN_IN.req_hi)
      ##0 s_no_sw1 |=> cnt1_q == $past(cnt1_q) + 32'h1)
    else $error("catch-all did not count");
  AST_WR_NOSNP: assert property (TXN_IN.valid && TXN_IN.is_write
      && |(sec_q[`OFR_SUP_MSB:`OFR_SUP_LSB] & TXN_IN.supplier)
      && req_match(sec_q, TXN_IN.prefetch, TXN_IN.req_lo, TXN_IN.req_hi)
      ##0 s_no_sw1 |=> cnt1_q == $past(cnt1_q) + 32'h1)
    else $error("write not counted on supplier match");
  AST_RD_SNP: assert property (TXN_IN.valid && !TXN_IN.is_write
      && !sec_q[`OFR_ANY_BIT] && !(|(sec_q[`OFR_SNP_MSB:`OFR_SNP_LSB] & TXN_IN.snoop))
      ##0 s_no_sw1 |=> $stable(cnt1_q))
    else $error("read counted without snoop match");
  AST_PREF: assert property (TXN_IN.valid && TXN_IN.prefetch
      && TXN_IN.req_lo == 16'h0001 && TXN_IN.req_hi == 6'h00 |-> !hit0 && !hit1)
    else $error("prefetch counted as demand load");
  AST_ACK_PULSE: assert property (bus_req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("ack not a single pulse after one wait");
  AST_FAULT_HOLD: assert property (fault_q && !wr_fire |=> fault_q)
    else $error("fault flag lost");

endmodule

// >>> testbench/ofr_uncore_model.sv
// Behavioural model of the core-to-uncore transaction path
`timescale 1ns/1ps
module ofr_uncore_model
  import ofr_pkg::*;
(
  input  wire logic     clk_in,
  input  wire logic     issue_in,
  input  wire logic     retire_in,
  input  wire ofr_txn_t txn_in,
  output ofr_txn_t      txn_out,
  output ofr_cpl_t      cpl_out
);
  ofr_txn_t last_q;  // Last issued request, retired later
  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle pulses; idle fields toggle so a stale value is never read as data
  always @(posedge clk_in) begin
    if (issue_in) begin
      txn_out <= txn_in;
      last_q  <= txn_in;
    end else begin
      // Valid is the top field; one assignment keeps a single write per edge
      txn_out <= {1'b0, ~txn_out[$bits(ofr_txn_t)-2:0]};
    end
    if (retire_in) begin
      cpl_out <= '{valid: 1'b1, prefetch: last_q.prefetch, req_lo: last_q.req_lo,
                   req_hi: last_q.req_hi};
    end else begin
      cpl_out <= {1'b0, ~cpl_out[$bits(ofr_cpl_t)-2:0]};
    end
  end
endmodule

// >>> testbench/offcore_response_event_filter_tb.sv
// Self-checking bench of the offcore response filter
`timescale 1ns/1ps
`include "ofr_defines.svh"
module offcore_response_event_filter_tb;
  import ofr_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  ofr_wb_req_t wb_req  = '0;
  ofr_wb_rsp_t wb_rsp;
  ofr_txn_t    txn;
  ofr_txn_t    pend    = '0;
  ofr_cpl_t    cpl;
  logic        issue   = 1'b0;
  logic        retire  = 1'b0;
  logic        fault;
  logic [31:0] cnt0, cnt1, rd, e0, e1, base, old;
  logic [63:0] pf, sf;
  ofr_txn_t    t;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  int          hits;
  int          occ_e      = 0;  // Matching requests issued and not yet retired

  always #20 clk_sys = ~clk_sys;

  ofr_filter i_dut (.CLK_SYS_IN(clk_sys), .RST_IN(rst), .WB_REQ_IN(wb_req),
    .WB_RSP_OUT(wb_rsp), .TXN_IN(txn), .CPL_IN(cpl), .FAULT_OUT(fault),
    .COUNT0_OUT(cnt0), .COUNT1_OUT(cnt1));
  ofr_uncore_model i_far (.clk_in(clk_sys), .issue_in(issue), .retire_in(retire),
    .txn_in(pend), .txn_out(txn), .cpl_out(cpl));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, report and close
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Classic Wishbone cycle; a stuck slave is caught by the hang guard
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_sys);
    end while (wb_rsp.ack !== 1'b1);
    r = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Expected request match; a prefetch is never a demand read
  function automatic logic rqm(input logic [63:0] f, input ofr_txn_t q);
    return |(f[15:0] & `OFR_REQ_LO_MASK & q.req_lo & {15'h7FFF, ~q.prefetch}) |
           |(f[49:44] & q.req_hi);
  endfunction
  // Expected match of one filter against one transaction
  function automatic logic hit(input logic [63:0] f, input ofr_txn_t q);
    logic sp;
    sp = |(f[30:17] & q.supplier) & (|(f[37:31] & q.snoop) | q.is_write);
    return rqm(f, q) & (f[16] | sp);
  endfunction
  // Hand one transaction to the far side and let the counters settle
  task send(input ofr_txn_t q);
    @(posedge clk_sys);
    pend  <= q;
    issue <= 1'b1;
    @(posedge clk_sys);
    issue <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(92));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    wb(1'b0, `OFR_ADR_PRIM_LO, 32'h0, rd); chk(rd, 32'h0);
    wb(1'b0, `OFR_ADR_SEC_HI, 32'h0, rd); chk(rd, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    wb(1'b0, 8'h1C, 32'h0, rd); chk(rd, 32'h0);
    e0 = 32'h0;
    e1 = 32'h0;
    // Random filters with corners: catch-all plus memory, then all snoop bits
    for (int k = 0; k < 6; k++) begin
      pf = {$urandom & $urandom & 32'h7FFFFFFF, $urandom & $urandom};
      sf = {$urandom & $urandom & 32'h7FFFFFFF, $urandom & $urandom};
      if (k == 0) pf = 64'h0000000004010001;
      if (k == 1) pf = 64'h0000003F84000001;
      wr(`OFR_ADR_PRIM_LO, pf[31:0]);
      wr(`OFR_ADR_PRIM_HI, pf[63:32]);
      wr(`OFR_ADR_SEC_LO, sf[31:0]);
      wr(`OFR_ADR_SEC_HI, sf[63:32]);
      wb(1'b0, `OFR_ADR_PRIM_HI, 32'h0, rd); chk(rd, pf[63:32]);
      wb(1'b0, `OFR_ADR_SEC_LO, 32'h0, rd); chk(rd, sf[31:0]);
      for (int j = 0; j < 10; j++) begin
        t          = '0;
        t.valid    = 1'b1;
        t.is_write = 1'($urandom % 2);
        t.prefetch = 1'($urandom % 2);
        t.req_lo   = 16'h1 << ($urandom % 16);
        t.req_hi   = ($urandom % 3 == 0) ? 6'h1 << ($urandom % 6) : 6'h0;
        t.supplier = 14'h1 << ($urandom % 14);
        t.snoop    = ($urandom % 2 == 0) ? 7'h1 << ($urandom % 7) : 7'h0;
        // Corner: a prefetch that looks like a demand read
        if (j == 0) begin
          t.prefetch = 1'b1;
          t.req_lo   = 16'h0001;
          t.req_hi   = 6'h00;
        end
        send(t);
        // Issues are never retired here, so the occupancy keeps them
        occ_e += int'(rqm(pf, t));
        e0 = e0 + 32'(hit(pf, t));
        e1 = e1 + 32'(hit(sf, t));
        chk(cnt0, e0);
        chk(cnt1, e1);
      end
    end
    // Setting the in-flight bit of the secondary filter is refused
    wb(1'b0, `OFR_ADR_SEC_HI, 32'h0, old);
    wr(`OFR_ADR_SEC_HI, 32'h80000001);
    hits = 0;
    repeat (3) begin
      #1 hits += int'(fault);
      @(posedge clk_sys);
    end
    chk(32'(hits), 32'h1);
    wb(1'b0, `OFR_ADR_SEC_HI, 32'h0, rd); chk(rd, old);
    wb(1'b0, `OFR_ADR_STATUS, 32'h0, rd); chk({31'h0, rd[0]}, 32'h1);
    wr(`OFR_ADR_STATUS, 32'h1);
    wb(1'b0, `OFR_ADR_STATUS, 32'h0, rd); chk({31'h0, rd[0]}, 32'h0);
    // In-flight mode: every outstanding matching request adds one per cycle
    wr(`OFR_ADR_PRIM_LO, 32'h00000001);
    wr(`OFR_ADR_PRIM_HI, 32'h80000000);
    // Occurrence counter with the same request kind and a catch-all response
    wr(`OFR_ADR_SEC_LO, 32'h00010001);
    wr(`OFR_ADR_SEC_HI, 32'h00000000);
    e1       = cnt1;
    t        = '0;
    t.valid  = 1'b1;
    t.req_lo = 16'h0001;
    send(t);
    occ_e++;
    chk(cnt1, e1 + 32'h1);
    wb(1'b0, `OFR_ADR_STATUS, 32'h0, rd);
    chk({16'h0, rd[15:0] & 16'hFF02}, {16'h0, 8'(occ_e), 8'h02});
    #1 base = cnt0;
    repeat (5) @(posedge clk_sys);
    #1 chk(cnt0 - base, 32'(5 * occ_e));
    @(posedge clk_sys);
    retire <= 1'b1;
    @(posedge clk_sys);
    retire <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 base = cnt0;
    repeat (4) @(posedge clk_sys);
    #1 chk(cnt0 - base, 32'(4 * (occ_e - 1)));
    tally_and_finish();
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
endmodule
